// ===== rtl/cxm_transceiver.sv
module cxm_transceiver
#(
   parameter int FILTER_CYC       = cxm_pkg::FILTER_CYC,
   parameter int WAKE_WINDOW_CYC  = cxm_pkg::WAKE_WINDOW_CYC,
   parameter int TIMEOUT_CYC      = cxm_pkg::DOMINANT_TIMEOUT_CYC,
   parameter int CLAMP_CYC        = cxm_pkg::CLAMP_DETECT_CYC,
   parameter int REARM_CYC        = cxm_pkg::TXD_REARM_CYC
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // Controller side
   input  wire logic txd,
   input  wire logic standby_select,
   output logic      rxd_r,
   input  wire logic rxd_pin_level,
   // Bus side
   input  wire logic bus_comparator,
   input  wire logic wake_comparator,
   output logic      bus_dominant_r,
   // Supervisors
   input  wire logic uv_vcc,
   input  wire logic uv_vio,
   input  wire logic overtemp,
   // Status
   output logic      mode_normal_r,
   output logic      wake_pattern_r,
   output logic      silent_r
);

   localparam int CW = cxm_pkg::CNT_W;

   // Saturating increment shared by all timers.
   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
      sat_inc = (&v) ? v : v + 24'h1;
   endfunction : sat_inc

   cxm_pkg::cxm_mode_t mode_r;
   cxm_pkg::cxm_mode_t mode_nxt;
   cxm_pkg::cxm_wake_t wst_r;
   cxm_pkg::cxm_wake_t wst_nxt;
   logic [CW-1:0] flt_cnt_r;
   logic [CW-1:0] win_cnt_r;
   logic [CW-1:0] dom_cnt_r;
   logic [CW-1:0] high_cnt_r;
   logic [CW-1:0] clamp_cnt_r;
   logic          wake_lvl_r;
   logic          timeout_r;
   logic          ot_block_r;
   logic          wake_flag_r;

   // Supply state and mode selection.
   wire uv          = uv_vcc || uv_vio;
   wire want_normal = !standby_select && txd;
   wire is_normal   = (mode_r == cxm_pkg::CXM_NORMAL);
   wire is_standby  = (mode_r == cxm_pkg::CXM_STANDBY);

   always_comb
   begin
      mode_nxt = mode_r;
      if (uv)
         mode_nxt = cxm_pkg::CXM_UNPOWERED;
      else if (standby_select)
         mode_nxt = cxm_pkg::CXM_STANDBY;
      else if (want_normal)
         mode_nxt = cxm_pkg::CXM_NORMAL;
      else if (mode_r == cxm_pkg::CXM_UNPOWERED)
         mode_nxt = cxm_pkg::CXM_STANDBY;
   end

   // Wake detector: the comparator level must differ from the stored one for the filter time.
   wire lvl_changed = (wake_comparator != wake_lvl_r);
   wire flt_done    = lvl_changed && (flt_cnt_r >= CW'(FILTER_CYC - 1));
   wire win_expired = (wst_r != cxm_pkg::CXM_W_IDLE) && (win_cnt_r >= CW'(WAKE_WINDOW_CYC));
   wire wake_en     = is_standby && !uv;

   always_comb
   begin
      wst_nxt = wst_r;
      if (!wake_en || win_expired)
         wst_nxt = cxm_pkg::CXM_W_IDLE;
      else if (flt_done)
      begin
         unique case (wst_r)
            cxm_pkg::CXM_W_IDLE: wst_nxt = wake_comparator ? cxm_pkg::CXM_W_DOM1 : wst_r;
            cxm_pkg::CXM_W_DOM1: wst_nxt = cxm_pkg::CXM_W_REC;
            cxm_pkg::CXM_W_REC:  wst_nxt = cxm_pkg::CXM_W_DOM2;
            cxm_pkg::CXM_W_DOM2: wst_nxt = cxm_pkg::CXM_W_DOM2;
         endcase
      end
   end

   wire wake_hit = wake_en && !win_expired && flt_done && (wst_r == cxm_pkg::CXM_W_REC);
   // The flag follows the next mode, so it is gone in the very edge that leaves Standby.
   wire stay_standby = (mode_nxt == cxm_pkg::CXM_STANDBY);

   // Transmit time-out, overtemperature and clamp gating.
   wire tx_ok      = is_normal && !timeout_r && !ot_block_r && !silent_r;
   // Supply and temperature gate the driver directly, so it lets go without waiting for the mode.
   wire drive_dom  = tx_ok && !txd && !uv && !overtemp;
   wire clamp_seen = is_normal && bus_comparator && rxd_pin_level;

   // The receive level passes through a two-entry buffer so a held word is never dropped.
   logic buf_valid;
   logic buf_ready;
   logic buf_data;
   wire  rx_level_in = is_normal ? !bus_comparator : !wake_flag_r;

   cxm_buf2 cxm_buf2_i
   (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .in_valid  (1'b1),
      .in_ready  (buf_ready),
      .in_data   (rx_level_in),
      .out_valid (buf_valid),
      .out_ready (1'b1),
      .out_data  (buf_data)
   );

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mode_r     <= cxm_pkg::CXM_UNPOWERED;
         wst_r      <= cxm_pkg::CXM_W_IDLE;
         flt_cnt_r  <= '0;
         win_cnt_r  <= '0;
         wake_lvl_r <= 1'b0;
      end
      else
      begin
         mode_r <= mode_nxt;
         wst_r  <= wst_nxt;
         flt_cnt_r  <= lvl_changed ? (flt_done ? '0 : sat_inc(flt_cnt_r)) : '0;
         if (flt_done)
            wake_lvl_r <= wake_comparator;
         win_cnt_r <= (wst_nxt == cxm_pkg::CXM_W_IDLE) ? '0 : sat_inc(win_cnt_r);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         wake_flag_r <= 1'b0;
      else if (wake_hit && stay_standby)
         wake_flag_r <= 1'b1;
      else if (!stay_standby)
         wake_flag_r <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         dom_cnt_r  <= '0;
         high_cnt_r <= '0;
         timeout_r  <= 1'b0;
      end
      else
      begin
         dom_cnt_r  <= txd ? '0 : sat_inc(dom_cnt_r);
         high_cnt_r <= txd ? sat_inc(high_cnt_r) : '0;
         if (!txd && dom_cnt_r >= CW'(TIMEOUT_CYC))
            timeout_r <= 1'b1;
         else if (txd && high_cnt_r >= CW'(REARM_CYC - 1))
            timeout_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ot_block_r <= 1'b0;
      else if (overtemp)
         ot_block_r <= 1'b1;
      else if (txd)
         ot_block_r <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         clamp_cnt_r <= '0;
         silent_r    <= 1'b0;
      end
      else
      begin
         clamp_cnt_r <= clamp_seen ? sat_inc(clamp_cnt_r) : '0;
         if (!is_normal || !rxd_pin_level)
            silent_r <= 1'b0;
         else if (clamp_seen && clamp_cnt_r >= CW'(CLAMP_CYC - 1))
            silent_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         bus_dominant_r <= cxm_pkg::RST_BUS_DOM;
         rxd_r          <= cxm_pkg::RST_RXD;
         mode_normal_r  <= 1'b0;
         wake_pattern_r <= 1'b0;
      end
      else
      begin
         bus_dominant_r <= drive_dom;
         if (uv)
            rxd_r <= 1'b1;
         else if (buf_valid)
            rxd_r <= buf_data;
         mode_normal_r  <= is_normal;
         wake_pattern_r <= wake_flag_r;
      end
   end

   // Assertions.
   no_wake_normal_a: assert property (@(posedge ref_clk) disable iff (srst)
      is_normal |-> !wake_flag_r)
      else $error("Wake flag set in Normal mode.");
   uv_release_a: assert property (@(posedge ref_clk) disable iff (srst)
      uv |=> !bus_dominant_r)
      else $error("Bus driven during undervoltage.");
   standby_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
      (standby_select && !uv) |=> mode_r == cxm_pkg::CXM_STANDBY)
      else $error("Standby select did not give Standby.");
   no_normal_txd_low_a: assert property (@(posedge ref_clk) disable iff (srst)
      (!is_normal && !txd) |=> !is_normal)
      else $error("Normal entered with transmit low.");
   enter_normal_a: assert property (@(posedge ref_clk) disable iff (srst)
      (want_normal && !uv) |=> is_normal)
      else $error("Normal not entered.");
   timeout_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
      timeout_r |=> !bus_dominant_r)
      else $error("Driver active after time-out.");
   ot_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
      overtemp |=> ##1 !bus_dominant_r)
      else $error("Driver active under overtemperature.");
   silent_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
      (silent_r && !is_normal) |=> !silent_r)
      else $error("Silent state held outside Normal.");
   wake_window_a: assert property (@(posedge ref_clk) disable iff (srst)
      win_expired |=> wst_r == cxm_pkg::CXM_W_IDLE)
      else $error("Wake detector not reset after window.");
   wake_rxd_a: assert property (@(posedge ref_clk) disable iff (srst)
      (wake_hit && !uv) |=> ##2 (!rxd_r || !is_standby))
      else $error("Wake not shown on receive output.");

   // Receive path, driver gating and undervoltage mode.
   rxbuf_room_a: assert property (@(posedge ref_clk) disable iff (srst)
      buf_ready)
      else $error("Receive buffer filled up.");
   rx_dominant_a: assert property (@(posedge ref_clk) disable iff (srst)
      (is_normal && bus_comparator) ##1 !uv |=> !rxd_r)
      else $error("Receive not low on dominant bus.");
   rx_recessive_a: assert property (@(posedge ref_clk) disable iff (srst)
      (is_normal && !bus_comparator) ##1 !uv |=> rxd_r)
      else $error("Receive not high on recessive bus.");
   standby_rxd_a: assert property (@(posedge ref_clk) disable iff (srst)
      (is_standby && !wake_flag_r) ##1 !uv |=> rxd_r)
      else $error("Receive low in Standby without wake.");
   idle_recessive_a: assert property (@(posedge ref_clk) disable iff (srst)
      !is_normal |=> !bus_dominant_r)
      else $error("Driver active outside Normal.");
   silent_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
      silent_r |=> !bus_dominant_r)
      else $error("Driver active in silent state.");
   uv_rxd_a: assert property (@(posedge ref_clk) disable iff (srst)
      uv |=> rxd_r)
      else $error("Receive low during undervoltage.");
   uv_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
      uv |=> mode_r == cxm_pkg::CXM_UNPOWERED)
      else $error("Mode kept during undervoltage.");

   // Timers and latched blocks.
   timeout_count_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(timeout_r) |-> $past(dom_cnt_r) >= CW'(TIMEOUT_CYC))
      else $error("Time-out taken too early.");
   timeout_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      (timeout_r && !txd) |=> timeout_r)
      else $error("Time-out left with transmit low.");
   rearm_short_a: assert property (@(posedge ref_clk) disable iff (srst)
      (timeout_r && high_cnt_r < CW'(REARM_CYC - 1)) |=> timeout_r)
      else $error("Time-out left after a short high.");
   rearm_count_a: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(timeout_r) |-> $past(txd) && $past(high_cnt_r) >= CW'(REARM_CYC - 1))
      else $error("Time-out cleared without a long high.");
   ot_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
      overtemp |=> ot_block_r)
      else $error("Overtemperature not latched.");
   ot_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      (ot_block_r && !txd) |=> ot_block_r)
      else $error("Overtemperature block left with transmit low.");
   ot_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(ot_block_r) |-> $past(txd) && !$past(overtemp))
      else $error("Overtemperature block cleared too early.");
   silent_count_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(silent_r) |-> $past(clamp_cnt_r) >= CW'(CLAMP_CYC - 1))
      else $error("Silent state entered too early.");
   clamp_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
      (is_normal && !rxd_pin_level) |=> !silent_r)
      else $error("Silent state kept with receive low.");

   // Wake detector.
   filter_count_a: assert property (@(posedge ref_clk) disable iff (srst)
      $changed(wake_lvl_r) |-> $past(flt_cnt_r) >= CW'(FILTER_CYC - 1))
      else $error("Bus level taken before the filter time.");
   wake_standby_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(wake_flag_r) |-> $past(is_standby) && is_standby)
      else $error("Wake flagged outside Standby.");
   wake_sequence_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(wake_flag_r) |-> $past(wst_r) == cxm_pkg::CXM_W_REC)
      else $error("Wake flagged without the full pattern.");
   wake_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
      !wake_en |=> wst_r == cxm_pkg::CXM_W_IDLE)
      else $error("Wake detector running while disabled.");
   flag_standby_a: assert property (@(posedge ref_clk) disable iff (srst)
      !is_standby |-> !wake_flag_r)
      else $error("Wake flag held outside Standby.");

   wake_seen_c: cover property (@(posedge ref_clk) disable iff (srst) wake_hit);
   timeout_c:   cover property (@(posedge ref_clk) disable iff (srst) $rose(timeout_r));
   silent_c:    cover property (@(posedge ref_clk) disable iff (srst) $rose(silent_r));
   normal_c:    cover property (@(posedge ref_clk) disable iff (srst) $rose(is_normal));
   expire_c:    cover property (@(posedge ref_clk) disable iff (srst) win_expired);

endmodule : cxm_transceiver

// ===== rtl/cxm_pkg.sv
package cxm_pkg;

   // All times are in nanoseconds; counts are cycles of the 8 ns reference clock.
   localparam int CLK_PERIOD_NS           = 8;
   localparam int TXD_REARM_NS            = 4000;
   localparam int TXD_REARM_CYC           = TXD_REARM_NS / CLK_PERIOD_NS + 1;
   localparam int FILTER_NS               = 3800;
   localparam int FILTER_CYC              = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_WINDOW_NS          = 1000000;
   localparam int WAKE_WINDOW_CYC         = WAKE_WINDOW_NS / CLK_PERIOD_NS;
   localparam int DOMINANT_TIMEOUT_NS     = 1000000;
   localparam int DOMINANT_TIMEOUT_CYC    = (DOMINANT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLAMP_DETECT_NS         = 1000;
   localparam int CLAMP_DETECT_CYC        = (CLAMP_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W                   = 24;

   // Reset values of the pin-facing flops.
   localparam logic RST_BUS_DOM  = 1'b0;
   localparam logic RST_RXD      = 1'b1;

   // Operating mode, Gray coded along unpowered -> standby -> normal.
   typedef enum logic [1:0]
   {
      CXM_UNPOWERED = 2'b00,
      CXM_STANDBY   = 2'b01,
      CXM_NORMAL    = 2'b11
   } cxm_mode_t;

   // Wake pattern detector, Gray coded along its usual path.
   typedef enum logic [1:0]
   {
      CXM_W_IDLE = 2'b00,
      CXM_W_DOM1 = 2'b01,
      CXM_W_REC  = 2'b11,
      CXM_W_DOM2 = 2'b10
   } cxm_wake_t;

endpackage : cxm_pkg

// ===== rtl/cxm_buf2.sv
// Two-entry skid buffer carrying the receive level (bus level in Normal, inverted wake flag otherwise) towards the receive pin.
module cxm_buf2
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // Fill side
   input  wire logic in_valid,
   output logic      in_ready,
   input  wire logic in_data,
   // Drain side
   output logic      out_valid,
   input  wire logic out_ready,
   output logic      out_data
);

   logic [1:0] mem_r;
   logic [1:0] cnt_r;
   logic       rd_ptr_r;
   logic       wr_ptr_r;
   wire        push = in_valid && in_ready;
   wire        pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cnt_r    <= 2'h0;
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
         mem_r    <= 2'h3;
      end
      else
      begin
         if (push)
         begin
            mem_r[wr_ptr_r] <= in_data;
            wr_ptr_r        <= ~wr_ptr_r;
         end
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : cxm_buf2

// ===== verification/cxm_ctrl_model.sv
// Controller stand-in: drives transmit and standby select, and shows the receive pin level.
module cxm_ctrl_model
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // Requests from the bench
   input  wire logic req_txd,
   input  wire logic req_standby_select,
   input  wire logic answer_wake,
   input  wire logic clamp_rxd,
   // Transceiver side
   input  wire logic rxd_r,
   output logic      txd,
   output logic      standby_select,
   output logic      rxd_pin_level
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] low_cnt_r;
   logic       woke_r;

   // A slow controller: it answers a wake request only after eight low cycles.
   always_ff @(posedge ref_clk)
   begin
      if (srst || !req_standby_select)
      begin
         low_cnt_r <= 4'h0;
         woke_r    <= 1'h0;
      end
      else if (answer_wake && !rxd_r && !woke_r)
      begin
         low_cnt_r <= low_cnt_r + 4'h1;
         woke_r    <= (low_cnt_r == 4'h7);
      end
   end

   assign standby_select = req_standby_select & ~woke_r;
   assign txd            = req_txd;
   // A clamped pin is shorted high, whatever the transceiver drives.
   assign rxd_pin_level  = clamp_rxd | rxd_r;
endmodule : cxm_ctrl_model

// ===== verification/can_transceiver_mode_failsafe_test.sv
`define CHK(got, exp, msg) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("MISMATCH %0t %s", $time, msg); \
      end \
   end

module can_transceiver_mode_failsafe_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'h0;
   logic srst, req_txd, req_standby_select, answer_wake, clamp_rxd, bus_lvl, uv_vcc, uv_vio, overtemp;
   logic txd, standby_select, rxd_pin_level, rxd_r, bus_dominant_r, mode_normal_r, wake_pattern_r, silent_r;
   int   comparisons = 0;
   int   fail_count  = 0;

   cxm_transceiver #(.FILTER_CYC(4), .WAKE_WINDOW_CYC(64), .TIMEOUT_CYC(32), .CLAMP_CYC(8), .REARM_CYC(10))
   cxm_transceiver_i (.ref_clk(ref_clk), .srst(srst), .txd(txd), .standby_select(standby_select),
      .rxd_r(rxd_r), .rxd_pin_level(rxd_pin_level), .bus_comparator(bus_lvl), .wake_comparator(bus_lvl),
      .bus_dominant_r(bus_dominant_r), .uv_vcc(uv_vcc), .uv_vio(uv_vio), .overtemp(overtemp),
      .mode_normal_r(mode_normal_r), .wake_pattern_r(wake_pattern_r), .silent_r(silent_r));

   cxm_ctrl_model cxm_ctrl_model_i (.ref_clk(ref_clk), .srst(srst), .req_txd(req_txd), .req_standby_select(req_standby_select),
      .answer_wake(answer_wake), .clamp_rxd(clamp_rxd), .rxd_r(rxd_r), .txd(txd),
      .standby_select(standby_select), .rxd_pin_level(rxd_pin_level));

   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   task automatic pattern(input int d1, input int r, input int d2);
      bus_lvl = 1'h1;
      cyc(d1);
      bus_lvl = 1'h0;
      cyc(r);
      bus_lvl = 1'h1;
      cyc(d2);
      bus_lvl = 1'h0;
   endtask : pattern

   task automatic close_out;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic t_entry;
      req_standby_select = 1'h0;
      req_txd  = 1'h0;
      cyc(6);
      `CHK(mode_normal_r, 1'h0, "normal entered with transmit low")
      req_txd = 1'h1;
      cyc(4);
      `CHK(mode_normal_r, 1'h1, "normal not entered")
      req_txd = 1'h0;
      cyc(2);
      `CHK(bus_dominant_r, 1'h1, "driver not dominant")
      bus_lvl = 1'h1;
      cyc(5);
      `CHK(rxd_r, 1'h0, "receive not low on dominant")
      bus_lvl = 1'h0;
      req_txd = 1'h1;
      cyc(5);
      `CHK(bus_dominant_r, 1'h0, "driver not recessive")
      `CHK(rxd_r, 1'h1, "receive not high on recessive")
   endtask : t_entry

   task automatic t_timeout;
      req_txd = 1'h0;
      cyc(40);
      `CHK(bus_dominant_r, 1'h0, "no dominant time-out")
      req_txd = 1'h1;
      cyc(3);
      req_txd = 1'h0;
      cyc(3);
      `CHK(bus_dominant_r, 1'h0, "rearmed by a short high")
      req_txd = 1'h1;
      cyc(15);
      req_txd = 1'h0;
      cyc(3);
      `CHK(bus_dominant_r, 1'h1, "not rearmed by a long high")
      req_txd = 1'h1;
      cyc(2);
   endtask : t_timeout

   task automatic t_overtemp;
      req_txd  = 1'h0;
      overtemp = 1'h1;
      cyc(4);
      `CHK(bus_dominant_r, 1'h0, "driver on while hot")
      overtemp = 1'h0;
      cyc(4);
      `CHK(bus_dominant_r, 1'h0, "driver on before transmit high")
      req_txd = 1'h1;
      cyc(2);
      req_txd = 1'h0;
      cyc(3);
      `CHK(bus_dominant_r, 1'h1, "driver not released after cooling")
      req_txd = 1'h1;
      cyc(2);
   endtask : t_overtemp

   task automatic t_clamp;
      clamp_rxd = 1'h1;
      bus_lvl   = 1'h1;
      cyc(14);
      `CHK(silent_r, 1'h1, "clamp not detected")
      req_txd = 1'h0;
      cyc(3);
      `CHK(bus_dominant_r, 1'h0, "silent state still transmits")
      req_txd   = 1'h1;
      clamp_rxd = 1'h0;
      cyc(4);
      `CHK(silent_r, 1'h0, "silent not left on receive low")
      bus_lvl = 1'h0;
      cyc(4);
   endtask : t_clamp

   task automatic t_wake;
      req_standby_select    = 1'h1;
      answer_wake = 1'h1;
      cyc(4);
      `CHK(mode_normal_r, 1'h0, "standby not entered")
      pattern(6, 6, 6);
      cyc(4);
      `CHK(rxd_r, 1'h0, "wake not signalled")
      `CHK(wake_pattern_r, 1'h1, "wake flag not shown")
      `CHK(mode_normal_r, 1'h0, "wake changed the mode itself")
      cyc(14);
      `CHK(mode_normal_r, 1'h1, "normal not entered after wake")
      answer_wake = 1'h0;
      req_standby_select    = 1'h0;
      cyc(2);
   endtask : t_wake

   task automatic t_nowake;
      req_standby_select = 1'h1;
      cyc(4);
      repeat (10)
      begin
         bus_lvl = 1'h1;
         cyc(2);
         bus_lvl = 1'h0;
         cyc(2);
      end
      `CHK(wake_pattern_r, 1'h0, "short levels woke")
      pattern(40, 40, 40);
      cyc(4);
      `CHK(rxd_r, 1'h1, "slow pattern woke")
      `CHK(wake_pattern_r, 1'h0, "slow pattern set wake flag")
      uv_vcc = 1'h1;
      pattern(6, 6, 6);
      cyc(4);
      `CHK(rxd_r, 1'h1, "wake under undervoltage")
      `CHK(wake_pattern_r, 1'h0, "wake flag under undervoltage")
      uv_vcc   = 1'h0;
      req_standby_select = 1'h0;
      cyc(6);
   endtask : t_nowake

   task automatic t_uv;
      req_txd = 1'h0;
      uv_vio  = 1'h1;
      cyc(4);
      `CHK(bus_dominant_r, 1'h0, "driver on under undervoltage")
      `CHK(mode_normal_r, 1'h0, "normal kept under undervoltage")
      uv_vio  = 1'h0;
      req_txd = 1'h1;
      cyc(6);
      `CHK(mode_normal_r, 1'h1, "no recovery after undervoltage")
   endtask : t_uv

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      close_out();
   end

   initial
   begin
      srst        = 1'h1;
      req_txd     = 1'h1;
      req_standby_select    = 1'h1;
      answer_wake = 1'h0;
      clamp_rxd   = 1'h0;
      bus_lvl     = 1'h0;
      uv_vcc      = 1'h0;
      uv_vio      = 1'h0;
      overtemp    = 1'h0;
      cyc(8);
      `CHK(rxd_r, 1'h1, "receive reset value")
      `CHK(bus_dominant_r, 1'h0, "driver reset value")
      srst = 1'h0;
      t_entry();
      t_timeout();
      t_overtemp();
      t_clamp();
      t_wake();
      t_nowake();
      t_uv();
      close_out();
   end
endmodule : can_transceiver_mode_failsafe_test
